//--- logic/pcg_clock_ctrl.sv
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// [RULE1] pll stays powered down after reset until software clears the power-down bit
// [RULE2] pll output is 400 MHz, halved, then divided by the system divider
// [RULE3] each crystal_select change refreshes the read-only pll_translation_reg
// [RULE4] normal mode drives the pll output; power-down mode disables it
// [RULE5] relock starts on crystal change or pll power-up; same value does not
// [RULE6] relock down-counter runs on main oscillator ticks, loaded with 0x1200
// [RULE7] pll not used as system clock until the relock counter expires
// [RULE8] enable and select in one write: stay on oscillator until lock
// [RULE9] lock raw flag and lock interrupt let software confirm pll use
// [RULE10] run mode clocks core and peripherals enabled in run_gate_set
// [RULE11] sleep stops core, keeps source; gates by sleep_gate_set if auto-gating
// [RULE12] deep sleep needs core deep-sleep bit before wfi; interrupt returns to run
// [RULE13] deep sleep stops core; gates by deepsleep_gate_set if auto-gating
// [RULE14] deep sleep uses main oscillator or internal one, powering main down
// [RULE15] pll running at entry: power down, divider from override, /16 or /64
// [RULE16] on wake restore source and frequency before re-enabling clocks
// [RULE17] ext_config_select makes extended register fields replace base ones
// [RULE18] software bypasses pll and clears use_sys_divider before reconfiguring
// [RULE19] crystal write loads pll settings; clearing power-down enables the pll
// [RULE20] software sets divider, polls lock flag, then leaves bypass
// [RULE21] software keeps a stable reference running before selecting the pll
// [RULE22] system divisor is the divider field plus one
// [RULE23] lock raw flag sits at bit 6 and sets when relock expires
// [RULE24] every relock trigger clears the lock flag and reloads the counter
// [RULE25] lock interrupt asserts only when lock flag and its mask are set
module pcg_clock_ctrl #(
	parameter int NGATE = 3,
	parameter logic [15:0] RELOCK_COUNT = pcg_pkg::RELOCK_LOAD
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic mosc_tick,
	input wire logic wfi_req,
	input wire logic deep_sleep_en,
	input wire logic wake_event,
	output pcg_pkg::pcg_clk_t clk_out,
	output logic sys_clk_en,
	output logic [13:0] pll_settings,
	output logic [32*NGATE-1:0] periph_clk_en,
	output logic pll_lock_irq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic in_bank(input logic [11:0] addr, input logic [11:0] base);
		return (addr >= base) && (addr < base + 12'(4 * NGATE)) && (addr[1:0] == 2'b00);
	endfunction

	function automatic pcg_pkg::pcg_cfg_t pick_cfg(input logic [31:0] base,
			input logic [31:0] ext);
		pcg_pkg::pcg_cfg_t c;
		if (ext[pcg_pkg::POS_EXT_SEL]) begin
			c.osc = ext[pcg_pkg::POS_EXT_OSC +: 3];
			c.bypass = ext[pcg_pkg::POS_BYPASS];
			c.pll_power_down = ext[pcg_pkg::POS_PLL_POWER_DOWN];
			c.sysclk_divider = ext[pcg_pkg::POS_EXT_DIV +: 6];
		end else begin
			c.osc = {1'b0, base[pcg_pkg::POS_OSC +: 2]};
			c.bypass = base[pcg_pkg::POS_BYPASS];
			c.pll_power_down = base[pcg_pkg::POS_PLL_POWER_DOWN];
			c.sysclk_divider = {2'b00, base[pcg_pkg::POS_SYSCLK_DIVIDER +: 4]};
		end
		return c;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic ack;
	logic [31:0] run_cfg;
	logic [31:0] run_cfg_ext;
	logic [31:0] dslp_cfg;
	logic irq_mask;
	logic lock_raw;
	logic pll_stable;
	logic pll_pd_q;
	logic pll_at_entry;
	logic relock_busy;
	logic [15:0] relock_cnt;
	logic [7:0] div_cnt;
	logic [31:0] run_gate [NGATE];
	logic [31:0] sleep_gate [NGATE];
	logic [31:0] deep_gate [NGATE];
	logic [31:0] rd_mux;
	pcg_pkg::pcg_mode_t mode;
	pcg_pkg::pcg_mode_t next_mode;

	// ----------------------------------------------------------------
	// avalon slave: one wait state on every access
	// ----------------------------------------------------------------
	wire bus_req = avs_read | avs_write;
	wire wr_hit = avs_write & ack;
	wire rd_cap = avs_read & ~ack;
	wire [1:0] gidx = avs_address[3:2];
	assign avs_waitrequest = bus_req & ~ack;

	wire wr_run_cfg = wr_hit && (avs_address == pcg_pkg::ADDR_RUN_CFG);
	wire wr_run_ext = wr_hit && (avs_address == pcg_pkg::ADDR_RUN_CFG_EXT);
	wire wr_dslp = wr_hit && (avs_address == pcg_pkg::ADDR_DSLP_CFG);
	wire wr_mask = wr_hit && (avs_address == pcg_pkg::ADDR_IRQ_MASK) && avs_byteenable[0];
	wire w1c_lock = wr_hit && (avs_address == pcg_pkg::ADDR_MASKED_IRQ) && avs_byteenable[0]
		&& avs_writedata[pcg_pkg::LOCK_BIT];
	wire wr_run_gate = wr_hit && in_bank(avs_address, pcg_pkg::ADDR_RUN_GATE);
	wire wr_sleep_gate = wr_hit && in_bank(avs_address, pcg_pkg::ADDR_SLEEP_GATE);
	wire wr_deep_gate = wr_hit && in_bank(avs_address, pcg_pkg::ADDR_DEEP_GATE);

	wire [31:0] next_run_cfg = wr_run_cfg ?
		be_merge(run_cfg, avs_writedata, avs_byteenable) : run_cfg;
	wire [31:0] next_run_cfg_ext = wr_run_ext ?
		be_merge(run_cfg_ext, avs_writedata, avs_byteenable) : run_cfg_ext;
	wire [31:0] next_dslp_cfg = wr_dslp ?
		be_merge(dslp_cfg, avs_writedata, avs_byteenable) : dslp_cfg;
	wire next_irq_mask = wr_mask ? avs_writedata[pcg_pkg::LOCK_BIT] : irq_mask;

	always_comb begin
		rd_mux = 32'h00000000;
		if (avs_address == pcg_pkg::ADDR_RAW_IRQ) begin
			rd_mux[pcg_pkg::LOCK_BIT] = lock_raw; // RULE23
		end else if (avs_address == pcg_pkg::ADDR_IRQ_MASK) begin
			rd_mux[pcg_pkg::LOCK_BIT] = irq_mask;
		end else if (avs_address == pcg_pkg::ADDR_MASKED_IRQ) begin
			rd_mux[pcg_pkg::LOCK_BIT] = lock_raw & irq_mask;
		end else if (avs_address == pcg_pkg::ADDR_RUN_CFG) begin
			rd_mux = run_cfg;
		end else if (avs_address == pcg_pkg::ADDR_PLL_XLAT) begin
			rd_mux = {18'h0, pll_settings}; // RULE3
		end else if (avs_address == pcg_pkg::ADDR_RUN_CFG_EXT) begin
			rd_mux = run_cfg_ext;
		end else if (avs_address == pcg_pkg::ADDR_DSLP_CFG) begin
			rd_mux = dslp_cfg;
		end else if (in_bank(avs_address, pcg_pkg::ADDR_RUN_GATE)) begin
			rd_mux = run_gate[gidx];
		end else if (in_bank(avs_address, pcg_pkg::ADDR_SLEEP_GATE)) begin
			rd_mux = sleep_gate[gidx];
		end else if (in_bank(avs_address, pcg_pkg::ADDR_DEEP_GATE)) begin
			rd_mux = deep_gate[gidx];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			ack <= bus_req & ~ack;
			if (rd_cap) begin
				avs_readdata <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	wire [3:0] next_crystal_select = next_run_cfg[pcg_pkg::POS_CRYSTAL_SELECT +: 4];
	wire crystal_select_change = next_crystal_select != run_cfg[pcg_pkg::POS_CRYSTAL_SELECT +: 4]; // RULE5

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			run_cfg <= pcg_pkg::RST_RUN_CFG; // RULE1
			run_cfg_ext <= pcg_pkg::RST_RUN_CFG_EXT;
			dslp_cfg <= pcg_pkg::RST_DSLP_CFG;
			irq_mask <= 1'b0;
			pll_settings <= pcg_pkg::RST_PLL_XLAT;
		end else begin
			run_cfg <= next_run_cfg;
			run_cfg_ext <= next_run_cfg_ext;
			dslp_cfg <= next_dslp_cfg;
			irq_mask <= next_irq_mask;
			if (crystal_select_change) begin
				pll_settings <= pcg_pkg::pll_translate(next_crystal_select); // RULE3 RULE19
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NGATE; i++) begin
				run_gate[i] <= (i == 0) ? pcg_pkg::RST_GATE0 : pcg_pkg::RST_GATE_N;
				sleep_gate[i] <= (i == 0) ? pcg_pkg::RST_GATE0 : pcg_pkg::RST_GATE_N;
				deep_gate[i] <= (i == 0) ? pcg_pkg::RST_GATE0 : pcg_pkg::RST_GATE_N;
			end
		end else begin
			for (int i = 0; i < NGATE; i++) begin
				if (wr_run_gate && (gidx == 2'(i))) begin
					run_gate[i] <= be_merge(run_gate[i], avs_writedata, avs_byteenable);
				end
				if (wr_sleep_gate && (gidx == 2'(i))) begin
					sleep_gate[i] <= be_merge(sleep_gate[i], avs_writedata, avs_byteenable);
				end
				if (wr_deep_gate && (gidx == 2'(i))) begin
					deep_gate[i] <= be_merge(deep_gate[i], avs_writedata, avs_byteenable);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// active configuration and pll power
	// ----------------------------------------------------------------
	wire pcg_pkg::pcg_cfg_t cfg = pick_cfg(run_cfg, run_cfg_ext); // RULE17
	wire ext_sel = run_cfg_ext[pcg_pkg::POS_EXT_SEL];
	wire in_deep = (mode == pcg_pkg::MODE_DEEP);
	wire deep_pll_off = in_deep & pll_at_entry;
	wire pll_pd = cfg.pll_power_down | deep_pll_off; // RULE4 RULE15 RULE19
	wire power_up = pll_pd_q & ~pll_pd; // RULE5
	wire relock_trig = crystal_select_change | power_up;

	// ----------------------------------------------------------------
	// relock timer on main oscillator ticks
	// ----------------------------------------------------------------
	wire relock_done = relock_busy & mosc_tick & (relock_cnt == 16'h0001) & ~relock_trig;
	wire next_lock_raw = relock_trig ? 1'b0 : (relock_done | (lock_raw & ~w1c_lock));
	wire next_pll_stable = (relock_trig | pll_pd) ? 1'b0 : (relock_done | pll_stable);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			relock_busy <= 1'b0;
			relock_cnt <= 16'h0000;
			pll_pd_q <= 1'b1;
			lock_raw <= 1'b0;
			pll_stable <= 1'b0;
			pll_lock_irq <= 1'b0;
		end else begin
			pll_pd_q <= pll_pd;
			lock_raw <= next_lock_raw; // RULE23 RULE24
			pll_stable <= next_pll_stable;
			pll_lock_irq <= next_lock_raw & next_irq_mask; // RULE9 RULE25
			if (relock_trig) begin
				relock_cnt <= RELOCK_COUNT; // RULE6 RULE24
				relock_busy <= 1'b1;
			end else if (relock_busy && mosc_tick) begin
				relock_cnt <= relock_cnt - 16'h0001; // RULE6
				relock_busy <= relock_cnt != 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// power mode sequencing
	// ----------------------------------------------------------------
	wire use_pll = ~cfg.bypass & pll_stable & ~pll_pd & ~in_deep; // RULE7 RULE8

	always_comb begin
		next_mode = mode;
		unique case (mode)
			pcg_pkg::MODE_RUN: begin
				if (wfi_req) begin
					next_mode = deep_sleep_en ? pcg_pkg::MODE_DEEP : pcg_pkg::MODE_SLEEP; // RULE12
				end
			end
			pcg_pkg::MODE_SLEEP: begin
				if (wake_event) begin
					next_mode = pcg_pkg::MODE_RUN;
				end
			end
			pcg_pkg::MODE_DEEP: begin
				if (wake_event) begin
					next_mode = pcg_pkg::MODE_WAKE; // RULE12
				end
			end
			pcg_pkg::MODE_WAKE: begin
				if (!pll_at_entry || use_pll) begin
					next_mode = pcg_pkg::MODE_RUN; // RULE16
				end
			end
			default: next_mode = pcg_pkg::MODE_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode <= pcg_pkg::MODE_RUN;
			pll_at_entry <= 1'b0;
		end else begin
			mode <= next_mode;
			if (mode == pcg_pkg::MODE_RUN && wfi_req && deep_sleep_en) begin
				pll_at_entry <= use_pll; // RULE15
			end
		end
	end

	// ----------------------------------------------------------------
	// source, divisor and oscillator power
	// ----------------------------------------------------------------
	wire use_div = run_cfg[pcg_pkg::POS_USE_DIV];
	wire [6:0] run_div = use_div ? (7'(cfg.sysclk_divider) + 7'h01) : 7'h01; // RULE22
	wire [5:0] ds_raw = dslp_cfg[pcg_pkg::POS_DS_DIV +: 6];
	wire [5:0] ds_lim = (ext_sel || ds_raw <= pcg_pkg::BASE_DIV_MAX) ? ds_raw
		: pcg_pkg::BASE_DIV_MAX;
	wire [2:0] ds_osc = dslp_cfg[pcg_pkg::POS_DS_OSC +: 3];
	wire ds_int = (ds_osc == pcg_pkg::OSC_INT) || (ds_osc == pcg_pkg::OSC_INT_DIV4);
	wire ds_alt = ds_osc != pcg_pkg::OSC_MAIN;
	pcg_pkg::pcg_clk_t next_clk;

	always_comb begin
		next_clk.source = in_deep ? ds_osc : cfg.osc; // RULE14
		next_clk.from_pll = use_pll; // RULE8 RULE10
		next_clk.divisor = deep_pll_off ? (7'(ds_lim) + 7'h01) : run_div; // RULE15
		next_clk.core_en = (mode == pcg_pkg::MODE_RUN); // RULE11 RULE13
		next_clk.pll_pd = pll_pd; // RULE4
		next_clk.mosc_pd = (in_deep && ds_alt) ? 1'b1 : run_cfg[pcg_pkg::POS_MOSC_DIS]; // RULE14
		next_clk.iosc_pd = (in_deep && ds_int) ? 1'b0 : run_cfg[pcg_pkg::POS_IOSC_DIS];
	end

	// pll path sees the fixed predivide ahead of the divisor
	wire [7:0] div_total = clk_out.from_pll ? 8'(pcg_pkg::PLL_PREDIV * clk_out.divisor)
		: {1'b0, clk_out.divisor}; // RULE2
	wire div_wrap = div_cnt >= (div_total - 8'h01);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			clk_out <= '{source: pcg_pkg::OSC_INT, from_pll: 1'b0, divisor: 7'h01,
				core_en: 1'b1, pll_pd: 1'b1, mosc_pd: 1'b1, iosc_pd: 1'b0};
			div_cnt <= 8'h00;
			sys_clk_en <= 1'b0;
		end else begin
			clk_out <= next_clk;
			div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'h01;
			sys_clk_en <= div_wrap;
		end
	end

	// ----------------------------------------------------------------
	// peripheral gating
	// ----------------------------------------------------------------
	wire acg = run_cfg[pcg_pkg::POS_ACG];

	genvar g;
	generate
		for (g = 0; g < NGATE; g++) begin : gate
			logic [31:0] sel;
			always_comb begin
				unique case (mode)
					pcg_pkg::MODE_SLEEP: sel = acg ? sleep_gate[g] : run_gate[g]; // RULE11
					pcg_pkg::MODE_DEEP, pcg_pkg::MODE_WAKE: begin
						sel = acg ? deep_gate[g] : run_gate[g]; // RULE13 RULE16
					end
					default: sel = run_gate[g]; // RULE10
				endcase
			end
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					periph_clk_en[32*g +: 32] <= (g == 0) ? pcg_pkg::RST_GATE0
						: pcg_pkg::RST_GATE_N;
				end else begin
					periph_clk_en[32*g +: 32] <= sel;
				end
			end
		end
	endgenerate

endmodule

//--- shared/pcg_pkg.sv
package pcg_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_RAW_IRQ = 12'h050;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h054;
	localparam logic [11:0] ADDR_MASKED_IRQ = 12'h058;
	localparam logic [11:0] ADDR_RUN_CFG = 12'h060;
	localparam logic [11:0] ADDR_PLL_XLAT = 12'h064;
	localparam logic [11:0] ADDR_RUN_CFG_EXT = 12'h070;
	localparam logic [11:0] ADDR_RUN_GATE = 12'h100;
	localparam logic [11:0] ADDR_SLEEP_GATE = 12'h110;
	localparam logic [11:0] ADDR_DEEP_GATE = 12'h120;
	localparam logic [11:0] ADDR_DSLP_CFG = 12'h144;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_RUN_CFG = 32'h07803AD1;
	localparam logic [31:0] RST_RUN_CFG_EXT = 32'h07802810;
	localparam logic [31:0] RST_GATE0 = 32'h00000040;
	localparam logic [31:0] RST_GATE_N = 32'h00000000;
	localparam logic [31:0] RST_DSLP_CFG = 32'h07800000;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POS_MOSC_DIS = 0;
	localparam int POS_IOSC_DIS = 1;
	localparam int POS_OSC = 4;
	localparam int POS_CRYSTAL_SELECT = 6;
	localparam int POS_BYPASS = 11;
	localparam int POS_PLL_POWER_DOWN = 13;
	localparam int POS_USE_DIV = 22;
	localparam int POS_SYSCLK_DIVIDER = 23;
	localparam int POS_ACG = 27;
	localparam int POS_EXT_SEL = 31;
	localparam int POS_EXT_OSC = 4;
	localparam int POS_EXT_DIV = 23;
	localparam int POS_DS_OSC = 4;
	localparam int POS_DS_DIV = 23;
	localparam int LOCK_BIT = 6;
	// ----------------------------------------------------------------
	// counts and codes
	// ----------------------------------------------------------------
	localparam logic [15:0] RELOCK_LOAD = 16'h1200;
	localparam int PLL_VCO_MHZ = 400;
	localparam logic [7:0] PLL_PREDIV = 8'h02;
	localparam logic [5:0] BASE_DIV_MAX = 6'h0F;
	localparam logic [2:0] OSC_MAIN = 3'h0;
	localparam logic [2:0] OSC_INT = 3'h1;
	localparam logic [2:0] OSC_INT_DIV4 = 3'h2;
	localparam logic [9:0] PLL_F_BASE = 10'h0C0;

	// crystal_select code to pll settings: {r, f}
	function automatic logic [13:0] pll_translate(input logic [3:0] crystal_select);
		return {crystal_select, 10'(PLL_F_BASE + {6'h00, crystal_select})};
	endfunction

	localparam logic [13:0] RST_PLL_XLAT = pll_translate(RST_RUN_CFG[POS_CRYSTAL_SELECT +: 4]);

	typedef enum logic [3:0] {
		MODE_RUN = 4'b0001,
		MODE_SLEEP = 4'b0010,
		MODE_DEEP = 4'b0100,
		MODE_WAKE = 4'b1000
	} pcg_mode_t;

	typedef struct packed {
		logic [2:0] osc;
		logic bypass;
		logic pll_power_down;
		logic [5:0] sysclk_divider;
	} pcg_cfg_t;

	typedef struct packed {
		logic [2:0] source;
		logic from_pll;
		logic [6:0] divisor;
		logic core_en;
		logic pll_pd;
		logic mosc_pd;
		logic iosc_pd;
	} pcg_clk_t;
endpackage

//--- tb/pcg_clock_ctrl_chk.sv
`timescale 1ns/1ps
module pcg_clock_ctrl_chk #(
	parameter int NGATE = 3,
	parameter logic [15:0] RELOCK_COUNT = pcg_pkg::RELOCK_LOAD
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic mosc_tick,
	input wire logic wfi_req,
	input wire logic deep_sleep_en,
	input wire logic wake_event,
	input wire pcg_pkg::pcg_clk_t clk_out,
	input wire logic sys_clk_en,
	input wire logic [13:0] pll_settings,
	input wire logic [32*NGATE-1:0] periph_clk_en,
	input wire logic pll_lock_irq
);
	// ----------------------------------------
	// oscillator ticks seen since the pll last powered up
	// ----------------------------------------
	logic [15:0] tick_cnt;
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			tick_cnt <= 16'h0000;
		else if (clk_out.pll_pd)
			tick_cnt <= 16'h0000;
		else if (mosc_tick && tick_cnt != 16'hFFFF)
			tick_cnt <= tick_cnt + 16'h0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	req_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("request not stalled in its first cycle");
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held beyond one cycle");
	sleep_stop_a: assert property (wfi_req && clk_out.core_en |-> ##[1:3] !clk_out.core_en)
		else $error("core clock not stopped after wait for interrupt");
	deep_pd_a: assert property (wfi_req && deep_sleep_en && clk_out.core_en && !clk_out.pll_pd
		|-> ##[1:3] clk_out.pll_pd && !clk_out.core_en)
		else $error("pll not powered down in deep sleep");
	relock_hold_a: assert property ($rose(clk_out.from_pll)
		|-> tick_cnt >= RELOCK_COUNT - 16'h0001)
		else $error("pll selected before relock count expired");
	pll_live_a: assert property ($rose(clk_out.pll_pd) |-> ##[0:1] !clk_out.from_pll)
		else $error("powered down pll still selected");
	div_range_a: assert property (clk_out.divisor != 7'h00 && clk_out.divisor <= 7'h40)
		else $error("divisor out of range");
	wake_order_a: assert property ($rose(clk_out.core_en) |-> $stable(clk_out.source))
		else $error("core clock enabled before source restored");
	sys_pulse_a: assert property (sys_clk_en && (clk_out.from_pll || clk_out.divisor != 7'h01)
		&& $stable(clk_out.divisor) && $stable(clk_out.from_pll) |=> !sys_clk_en)
		else $error("system clock enable too frequent");
	irq_clear_a: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
		&& avs_address == pcg_pkg::ADDR_MASKED_IRQ && avs_writedata[pcg_pkg::LOCK_BIT]
		|-> ##[1:2] !pll_lock_irq)
		else $error("lock interrupt not cleared");
	reset_pll_off_a: assert property ($fell(reset) |-> clk_out.pll_pd)
		else $error("pll running after reset");
endmodule
bind pcg_clock_ctrl pcg_clock_ctrl_chk #(.NGATE(NGATE), .RELOCK_COUNT(RELOCK_COUNT)) i_chk (
	.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest, .mosc_tick, .wfi_req, .deep_sleep_en, .wake_event,
	.clk_out, .sys_clk_en, .pll_settings, .periph_clk_en, .pll_lock_irq);

//--- tb/pcg_clock_ctrl_tb.sv
`timescale 1ns/1ps
module pcg_clock_ctrl_tb;
	localparam int NG = 3;
	localparam logic [15:0] RLK = 16'h0010;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [11:0] avs_address = 12'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata, rdata;
	logic avs_waitrequest, mosc_tick, wfi_req, deep_sleep_en, wake_event, sys_clk_en, pll_lock_irq;
	pcg_pkg::pcg_clk_t clk_out;
	logic [13:0] pll_settings;
	logic [32*NG-1:0] periph_clk_en;
	logic sleep_cmd = 1'b0;
	logic deep_cmd = 1'b0;
	logic [7:0] wake_delay = 8'h00;
	logic [31:0] gate [3][NG];
	int n_mismatch = 0;
	int checked = 0;
	int seed = 73;
	int ticks = 0;
	always #25 clk = ~clk;
	always @(posedge clk) if (mosc_tick === 1'b1) ticks <= ticks + 1;
	pcg_clock_ctrl #(.NGATE(NG), .RELOCK_COUNT(RLK)) i_pcg_clock_ctrl (.clk, .reset,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .mosc_tick, .wfi_req, .deep_sleep_en, .wake_event, .clk_out,
		.sys_clk_en, .pll_settings, .periph_clk_en, .pll_lock_irq);
	pcg_core_model i_pcg_core_model (.clk, .reset, .sleep_cmd, .deep_cmd, .wake_delay,
		.core_en(clk_out.core_en), .mosc_pd(clk_out.mosc_pd), .mosc_tick, .wfi_req,
		.deep_sleep_en, .wake_event);
	// ----------------------------------------
	// reference model and bus tasks
	// ----------------------------------------
	function automatic logic [13:0] xlat(input logic [3:0] x);
		return {x, 10'h0C0 + {6'h00, x}};
	endfunction
	function automatic logic [32*NG-1:0] bank(input int k);
		logic [32*NG-1:0] r;
		for (int i = 0; i < NG; i++) r[32*i +: 32] = gate[k][i];
		return r;
	endfunction
	task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rdata = avs_readdata;
		if (n >= 20) chk("waitrequest", 0, 1);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h00000000);
		chk("readdata", e, rdata);
	endtask
	task automatic wait_sig(input int which, input logic v);
		int n;
		n = 0;
		while (((which == 0) ? clk_out.core_en : clk_out.from_pll) !== v && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk("wait", 1, n < 400);
	endtask
	task automatic sleep(input logic dp, input logic [7:0] wd);
		sleep_cmd <= 1'b1;
		deep_cmd <= dp;
		wake_delay <= wd;
		@(posedge clk);
		sleep_cmd <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		print_verdict;
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		int t0, n;
		logic [11:0] a;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("pll_pd", 1, clk_out.pll_pd);
		rd_chk(pcg_pkg::ADDR_RUN_CFG, pcg_pkg::RST_RUN_CFG);
		rd_chk(pcg_pkg::ADDR_RUN_CFG_EXT, pcg_pkg::RST_RUN_CFG_EXT);
		rd_chk(pcg_pkg::ADDR_DSLP_CFG, pcg_pkg::RST_DSLP_CFG);
		rd_chk(pcg_pkg::ADDR_PLL_XLAT, {18'h0, xlat(4'hB)});
		bus(1'b1, 12'h0FC, 32'hFFFFFFFF);
		rd_chk(12'h0FC, 32'h00000000);
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < NG; i++) begin
				a = 12'h100 + 12'(16 * k + 4 * i);
				rd_chk(a, (i == 0) ? 32'h00000040 : 32'h00000000);
				gate[k][i] = $random(seed);
				bus(1'b1, a, gate[k][i]);
				rd_chk(a, gate[k][i]);
			end
		end
		chk("periph", bank(0), periph_clk_en);
		bus(1'b1, pcg_pkg::ADDR_RUN_CFG, 32'h09C00980);
		t0 = ticks;
		chk("pll_settings", xlat(4'h6), pll_settings);
		rdata = 32'h00000000;
		for (n = 0; n < 40 && rdata[6] !== 1'b1; n++) bus(1'b0, pcg_pkg::ADDR_RAW_IRQ, 32'h0);
		chk("relock", 1, (ticks - t0) inside {[RLK - 1 : RLK + 1]});
		chk("from_pll", 0, clk_out.from_pll);
		chk("irq", 0, pll_lock_irq);
		bus(1'b1, pcg_pkg::ADDR_IRQ_MASK, 32'h00000040);
		chk("irq", 1, pll_lock_irq);
		rd_chk(pcg_pkg::ADDR_MASKED_IRQ, 32'h00000040);
		bus(1'b1, pcg_pkg::ADDR_RUN_CFG, 32'h09C00180);
		repeat (3) @(posedge clk);
		chk("from_pll", 1, clk_out.from_pll);
		chk("divisor", 4, clk_out.divisor);
		do @(posedge clk); while (sys_clk_en !== 1'b1);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (sys_clk_en !== 1'b1 && n < 99);
		chk("period", 8, n);
		bus(1'b1, pcg_pkg::ADDR_MASKED_IRQ, 32'h00000040);
		rd_chk(pcg_pkg::ADDR_RAW_IRQ, 32'h00000000);
		chk("irq", 0, pll_lock_irq);
		bus(1'b1, pcg_pkg::ADDR_RUN_CFG, 32'h09C02180);
		repeat (2) @(posedge clk);
		chk("pll_pd", 1, clk_out.pll_pd);
		chk("from_pll", 0, clk_out.from_pll);
		bus(1'b1, pcg_pkg::ADDR_RUN_CFG, 32'h09C00180);
		repeat (40) @(posedge clk);
		chk("from_pll", 0, clk_out.from_pll);
		chk("source", 0, clk_out.source);
		bus(1'b1, pcg_pkg::ADDR_RUN_CFG, 32'h09C001C0);
		t0 = ticks;
		wait_sig(1, 1'b1);
		chk("relock", 1, (ticks - t0) inside {[RLK - 1 : RLK + 1]});
		chk("pll_settings", xlat(4'h7), pll_settings);
		bus(1'b1, pcg_pkg::ADDR_RUN_CFG, 32'h09C001C0);
		repeat (40) @(posedge clk);
		chk("from_pll", 1, clk_out.from_pll);
		rd_chk(pcg_pkg::ADDR_RAW_IRQ, 32'h00000040);
		sleep(1'b0, 8'h14);
		chk("core_en", 0, clk_out.core_en);
		chk("periph", bank(1), periph_clk_en);
		chk("run_clock", {1'b1, 7'h04}, {clk_out.from_pll, clk_out.divisor});
		wait_sig(0, 1'b1);
		repeat (2) @(posedge clk);
		chk("periph", bank(0), periph_clk_en);
		bus(1'b1, pcg_pkg::ADDR_RUN_CFG, 32'h01C001C0);
		sleep(1'b0, 8'h00);
		chk("periph", bank(0), periph_clk_en);
		wait_sig(0, 1'b1);
		bus(1'b1, pcg_pkg::ADDR_RUN_CFG, 32'h09C001C0);
		bus(1'b1, pcg_pkg::ADDR_DSLP_CFG, 32'h1F800010);
		sleep(1'b1, 8'h1E);
		chk("clk_out", {3'h1, 1'b0, 7'h10, 4'b0110}, clk_out);
		chk("periph", bank(2), periph_clk_en);
		wait_sig(0, 1'b1);
		repeat (2) @(posedge clk);
		chk("clk_out", {3'h0, 1'b1, 7'h04, 4'b1000}, clk_out);
		bus(1'b1, pcg_pkg::ADDR_RUN_CFG_EXT, 32'h9F800820);
		repeat (2) @(posedge clk);
		chk("ext_clock", {3'h2, 1'b0, 7'h40}, {clk_out.source, clk_out.from_pll, clk_out.divisor});
		print_verdict;
	end
endmodule

//--- tb/pcg_core_model.sv
`timescale 1ns/1ps
module pcg_core_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic sleep_cmd,
	input wire logic deep_cmd,
	input wire logic [7:0] wake_delay,
	input wire logic core_en,
	input wire logic mosc_pd,
	output logic mosc_tick,
	output logic wfi_req,
	output logic deep_sleep_en,
	output logic wake_event
);
	// ----------------------------------------
	// core and main oscillator
	// ----------------------------------------
	logic [1:0] tick_div;
	logic [7:0] wait_cnt;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_div <= 2'h0;
			mosc_tick <= 1'b0;
			wfi_req <= 1'b0;
			deep_sleep_en <= 1'b0;
			wake_event <= 1'b0;
			wait_cnt <= 8'h00;
		end else begin
			tick_div <= tick_div + 2'h1;
			// a powered-down main oscillator gives no ticks
			mosc_tick <= (tick_div == 2'h2) && !mosc_pd;
			wfi_req <= sleep_cmd;
			if (sleep_cmd)
				deep_sleep_en <= deep_cmd;
			if (core_en) begin
				wait_cnt <= wake_delay;
				wake_event <= 1'b0;
			end else if (wait_cnt != 8'h00)
				wait_cnt <= wait_cnt - 8'h01;
			else
				wake_event <= 1'b1;
		end
	end
endmodule
